// ==== rtl/trap_cause_pkg.sv ====
// Purpose: Shared constants for the machine trap cause logic.
// Assumes: 64-bit machine word, 32-bit Avalon-MM register bus with word addresses.
// Notes: Cause codes are 6 bits wide; the stored code field is bits 5:0, and trap entry clears the bits between it and the flag.
package trap_cause_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned MACHINE_WORD_WIDTH = 64;
  localparam int unsigned CODE_W = 6;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IRQ_FLAG_POS = 63;

  // ==========================================================================
  // Register word indices
  localparam logic [3:0] REG_CAUSE_LO = 4'h0;
  localparam logic [3:0] REG_CAUSE_HI = 4'h1;
  localparam logic [3:0] REG_EPC_LO = 4'h2;
  localparam logic [3:0] REG_EPC_HI = 4'h3;
  localparam logic [3:0] REG_TVAL_LO = 4'h4;
  localparam logic [3:0] REG_TVAL_HI = 4'h5;
  localparam logic [3:0] REG_CTRL = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // Field positions and reset values
  localparam int unsigned CTRL_MIS_FIRST_POS = 0;
  localparam int unsigned STATUS_LAST_IRQ_POS = 0;
  localparam int unsigned STATUS_TRAP_SEEN_POS = 1;
  localparam logic [63:0] CAUSE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EPC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] TVAL_RESET = 64'h0000_0000_0000_0000;
  localparam logic CTRL_MIS_FIRST_RESET = 1'b0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================================
  // Interrupt codes
  localparam logic [5:0] IRQ_SSW = 6'h01;
  localparam logic [5:0] IRQ_MSW = 6'h03;
  localparam logic [5:0] IRQ_STIMER = 6'h05;
  localparam logic [5:0] IRQ_MTIMER = 6'h07;
  localparam logic [5:0] IRQ_SEXT = 6'h09;
  localparam logic [5:0] IRQ_MEXT = 6'h0B;
  localparam logic [5:0] IRQ_LCOF = 6'h0D;

  // Exception codes
  localparam logic [5:0] EXC_IMISALIGN = 6'h00;
  localparam logic [5:0] EXC_IACCESS = 6'h01;
  localparam logic [5:0] EXC_ILLEGAL = 6'h02;
  localparam logic [5:0] EXC_BREAK = 6'h03;
  localparam logic [5:0] EXC_LMISALIGN = 6'h04;
  localparam logic [5:0] EXC_LACCESS = 6'h05;
  localparam logic [5:0] EXC_SMISALIGN = 6'h06;
  localparam logic [5:0] EXC_SACCESS = 6'h07;
  localparam logic [5:0] EXC_ECALL_U = 6'h08;
  localparam logic [5:0] EXC_ECALL_S = 6'h09;
  localparam logic [5:0] EXC_ECALL_M = 6'h0B;
  localparam logic [5:0] EXC_IPAGE = 6'h0C;
  localparam logic [5:0] EXC_LPAGE = 6'h0D;
  localparam logic [5:0] EXC_SPAGE = 6'h0F;
  localparam logic [5:0] EXC_DOUBLE = 6'h10;
  localparam logic [5:0] EXC_SWCHECK = 6'h12;
  localparam logic [5:0] EXC_HWERR = 6'h13;
  localparam logic [5:0] CUSTOM_LO_FIRST = 6'h18;
  localparam logic [5:0] CUSTOM_LO_LAST = 6'h1F;
  localparam logic [5:0] CUSTOM_HI_FIRST = 6'h30;

  // Privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;

endpackage

// ==== rtl/machine_trap_cause_logic.sv ====
// Purpose: Records cause, exception PC and trap value on machine trap entry.
// Assumes: Pipeline raises trap_commit_i for one cycle per committed trap.
// Notes: Registers sit on an Avalon-MM slave with one wait cycle per access.

// Overview of operation
// - Load cause register on every machine trap
// - Hardware writes cause only on trap entry
// - Top bit set for interrupts, clear otherwise
// - Code field holds supported codes only; software writes are stored unchecked
// - Loads load-class, stores and AMOs store-class
// - Privilege violations reported as illegal instruction
// - Software interrupts codes 1 and 3
// - Timer interrupts codes 5 and 7
// - External interrupts codes 9 and 11
// - Counter-overflow interrupt code 13
// - Fetch exception codes 0 to 3
// - Data access exception codes 4 to 7
// - Environment call code by originating privilege
// - Page faults codes 12, 13, 15
// - Double trap 16, software check 18, error 19
// - Custom codes only in custom ranges
// - Several exceptions: record only highest priority
// - Breakpoint, then fetch translation, then fetch access
// - Then illegal, misaligned target, ecall, breaks
// - Data: misaligned, translation, access, misaligned
// - Misaligned rank above or below data faults
// - Breaks share code; misaligned from control flow
// - Software check trap value zero or informative
// - Hardware error: PC and faulting address
// - Hardware error ranked where corruption detected
// - Exception PC records trapping instruction address
module machine_trap_cause_logic (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Trap commit from pipeline
  input wire logic trap_commit_i,
  input wire logic [63:0] trap_pc_i,
  input wire logic [63:0] fault_vaddr_i,
  input wire logic [63:0] swcheck_info_i,
  input wire logic [1:0] priv_i,
  input wire logic access_is_store_i,
  // Interrupt requests
  input wire logic irq_ssw_i,
  input wire logic irq_msw_i,
  input wire logic irq_stimer_i,
  input wire logic irq_mtimer_i,
  input wire logic irq_sext_i,
  input wire logic irq_mext_i,
  input wire logic irq_lcof_i,
  // Synchronous exceptions
  input wire logic exc_double_i,
  input wire logic exc_ibreak_i,
  input wire logic exc_ixlate_i,
  input wire logic exc_ixlate_page_i,
  input wire logic exc_iaccess_i,
  input wire logic exc_hwerr_fetch_i,
  input wire logic exc_illegal_i,
  input wire logic exc_imisalign_i,
  input wire logic exc_ecall_i,
  input wire logic exc_ebreak_i,
  input wire logic exc_dbreak_i,
  input wire logic exc_swcheck_i,
  input wire logic exc_dmisalign_i,
  input wire logic exc_dxlate_i,
  input wire logic exc_dxlate_page_i,
  input wire logic exc_daccess_i,
  input wire logic exc_hwerr_data_i,
  input wire logic exc_custom_i,
  input wire logic [5:0] exc_custom_code_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Captured trap state
  output logic [63:0] trap_cause_o,
  output logic [63:0] trap_epc_o,
  output logic [63:0] trap_tval_o,
  output logic trap_taken_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [63:0] trap_cause;
    logic [63:0] epc;
    logic [63:0] tval;
    logic mis_first;
    logic last_irq;
    logic trap_seen;
    logic taken;
    logic wait_req;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic any_irq;
  logic [5:0] irq_code;
  logic any_exc;
  logic [5:0] exc_code;
  logic [63:0] exc_tval;
  logic custom_ok;
  logic [63:0] sel_cause;
  logic bus_req;
  logic bus_ack;

  function automatic logic [31:0] merge_be(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [5:0] ecall_code(input logic [1:0] priv);
    logic [5:0] c;
    c = trap_cause_pkg::EXC_ECALL_M;
    if (priv == trap_cause_pkg::PRIV_U) begin
      c = trap_cause_pkg::EXC_ECALL_U;
    end else if (priv == trap_cause_pkg::PRIV_S) begin
      c = trap_cause_pkg::EXC_ECALL_S;
    end
    return c;
  endfunction

  // ==========================================================================
  // Interrupt selection: machine before supervisor, external first
  // The order among interrupts is our own; software reads the code, not the rank
  always_comb begin
    any_irq = irq_mext_i | irq_msw_i | irq_mtimer_i | irq_sext_i | irq_ssw_i | irq_stimer_i | irq_lcof_i;
    irq_code = trap_cause_pkg::IRQ_LCOF;
    if (irq_mext_i) begin
      irq_code = trap_cause_pkg::IRQ_MEXT;
    end else if (irq_msw_i) begin
      irq_code = trap_cause_pkg::IRQ_MSW;
    end else if (irq_mtimer_i) begin
      irq_code = trap_cause_pkg::IRQ_MTIMER;
    end else if (irq_sext_i) begin
      irq_code = trap_cause_pkg::IRQ_SEXT;
    end else if (irq_ssw_i) begin
      irq_code = trap_cause_pkg::IRQ_SSW;
    end else if (irq_stimer_i) begin
      irq_code = trap_cause_pkg::IRQ_STIMER;
    end
  end

  // ==========================================================================
  // Synchronous exception priority; one winner per instruction
  always_comb begin
    // Codes 32-47 are never produced from the custom path
    custom_ok = (exc_custom_code_i >= trap_cause_pkg::CUSTOM_LO_FIRST &&
                 exc_custom_code_i <= trap_cause_pkg::CUSTOM_LO_LAST) ||
                (exc_custom_code_i >= trap_cause_pkg::CUSTOM_HI_FIRST);
    any_exc = 1'b1;
    exc_tval = fault_vaddr_i;
    exc_code = '0;
    if (exc_double_i) begin
      exc_code = trap_cause_pkg::EXC_DOUBLE;
      exc_tval = '0;
    end else if (exc_ibreak_i) begin
      exc_code = trap_cause_pkg::EXC_BREAK;
    end else if (exc_ixlate_i) begin
      exc_code = exc_ixlate_page_i ? trap_cause_pkg::EXC_IPAGE : trap_cause_pkg::EXC_IACCESS;
    end else if (exc_iaccess_i) begin
      exc_code = trap_cause_pkg::EXC_IACCESS;
    end else if (exc_hwerr_fetch_i) begin
      exc_code = trap_cause_pkg::EXC_HWERR;
    end else if (exc_illegal_i) begin
      // Privilege violations arrive here too; no separate code exists
      exc_code = trap_cause_pkg::EXC_ILLEGAL;
      exc_tval = '0;
    end else if (exc_imisalign_i) begin
      exc_code = trap_cause_pkg::EXC_IMISALIGN;
    end else if (exc_ecall_i) begin
      exc_code = ecall_code(priv_i);
      exc_tval = '0;
    end else if (exc_ebreak_i || exc_dbreak_i) begin
      exc_code = trap_cause_pkg::EXC_BREAK;
    end else if (exc_swcheck_i) begin
      exc_code = trap_cause_pkg::EXC_SWCHECK;
      exc_tval = swcheck_info_i;
    end else if (exc_dmisalign_i && st_reg.mis_first) begin
      // Early rank suits cores that never support misaligned data
      exc_code = access_is_store_i ? trap_cause_pkg::EXC_SMISALIGN : trap_cause_pkg::EXC_LMISALIGN;
    end else if (exc_dxlate_i) begin
      if (exc_dxlate_page_i) begin
        exc_code = access_is_store_i ? trap_cause_pkg::EXC_SPAGE : trap_cause_pkg::EXC_LPAGE;
      end else begin
        exc_code = access_is_store_i ? trap_cause_pkg::EXC_SACCESS : trap_cause_pkg::EXC_LACCESS;
      end
    end else if (exc_daccess_i) begin
      exc_code = access_is_store_i ? trap_cause_pkg::EXC_SACCESS : trap_cause_pkg::EXC_LACCESS;
    end else if (exc_hwerr_data_i) begin
      exc_code = trap_cause_pkg::EXC_HWERR;
    end else if (exc_dmisalign_i) begin
      // Late rank suits cores that translate and check before judging alignment
      exc_code = access_is_store_i ? trap_cause_pkg::EXC_SMISALIGN : trap_cause_pkg::EXC_LMISALIGN;
    end else if (exc_custom_i && custom_ok) begin
      exc_code = exc_custom_code_i;
      exc_tval = '0;
    end else begin
      // Nothing raised: the code field stays zero with the flag clear
      any_exc = 1'b0;
      exc_tval = '0;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    bus_req = avs_read_i | avs_write_i;
    bus_ack = bus_req & ~st_reg.wait_req;
    // Interrupts win over exceptions on the same commit
    sel_cause = '0;
    sel_cause[trap_cause_pkg::IRQ_FLAG_POS] = any_irq;
    sel_cause[trap_cause_pkg::CODE_W-1:0] = any_irq ? irq_code : exc_code;
    st_next.taken = 1'b0;

    // Bus: one wait cycle, then answer and release for one cycle
    // A request still held after its answer is taken again, so it costs two cycles
    st_next.wait_req = ~(bus_req & st_reg.wait_req);
    if (bus_req && st_reg.wait_req && avs_read_i) begin
      unique case (avs_address_i)
        trap_cause_pkg::REG_CAUSE_LO: st_next.rdata = st_reg.trap_cause[31:0];
        trap_cause_pkg::REG_CAUSE_HI: st_next.rdata = st_reg.trap_cause[63:32];
        trap_cause_pkg::REG_EPC_LO: st_next.rdata = st_reg.epc[31:0];
        trap_cause_pkg::REG_EPC_HI: st_next.rdata = st_reg.epc[63:32];
        trap_cause_pkg::REG_TVAL_LO: st_next.rdata = st_reg.tval[31:0];
        trap_cause_pkg::REG_TVAL_HI: st_next.rdata = st_reg.tval[63:32];
        trap_cause_pkg::REG_CTRL: st_next.rdata = {31'h0000_0000, st_reg.mis_first};
        trap_cause_pkg::REG_STATUS: st_next.rdata = {30'h0000_0000, st_reg.trap_seen, st_reg.last_irq};
        default: st_next.rdata = trap_cause_pkg::UNMAPPED_READ;
      endcase
    end

    // Software writes; code field is stored as written, software keeps it legal
    if (bus_ack && avs_write_i) begin
      unique case (avs_address_i)
        trap_cause_pkg::REG_CAUSE_LO:
          st_next.trap_cause[31:0] = merge_be(st_reg.trap_cause[31:0], avs_writedata_i, avs_byteenable_i);
        trap_cause_pkg::REG_CAUSE_HI:
          st_next.trap_cause[63:32] = merge_be(st_reg.trap_cause[63:32], avs_writedata_i, avs_byteenable_i);
        trap_cause_pkg::REG_EPC_LO: begin
          st_next.epc[31:0] = merge_be(st_reg.epc[31:0], avs_writedata_i, avs_byteenable_i);
          st_next.epc[0] = 1'b0;
        end
        trap_cause_pkg::REG_EPC_HI:
          st_next.epc[63:32] = merge_be(st_reg.epc[63:32], avs_writedata_i, avs_byteenable_i);
        trap_cause_pkg::REG_TVAL_LO:
          st_next.tval[31:0] = merge_be(st_reg.tval[31:0], avs_writedata_i, avs_byteenable_i);
        trap_cause_pkg::REG_TVAL_HI:
          st_next.tval[63:32] = merge_be(st_reg.tval[63:32], avs_writedata_i, avs_byteenable_i);
        trap_cause_pkg::REG_CTRL: begin
          if (avs_byteenable_i[0]) begin
            st_next.mis_first = avs_writedata_i[trap_cause_pkg::CTRL_MIS_FIRST_POS];
          end
        end
        default: begin
        end
      endcase
    end

    // Trap entry overrides a software write to cause, exception PC or trap value in the same cycle
    if (trap_commit_i) begin
      st_next.trap_cause = sel_cause;
      st_next.epc = {trap_pc_i[63:1], 1'b0};
      st_next.tval = any_irq ? 64'h0000_0000_0000_0000 : exc_tval;
      st_next.last_irq = any_irq;
      st_next.trap_seen = 1'b1;
      st_next.taken = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg.trap_cause <= trap_cause_pkg::CAUSE_RESET;
      st_reg.epc <= trap_cause_pkg::EPC_RESET;
      st_reg.tval <= trap_cause_pkg::TVAL_RESET;
      st_reg.mis_first <= trap_cause_pkg::CTRL_MIS_FIRST_RESET;
      st_reg.last_irq <= 1'b0;
      st_reg.trap_seen <= 1'b0;
      st_reg.taken <= 1'b0;
      st_reg.wait_req <= 1'b1;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.wait_req;
  assign trap_cause_o = st_reg.trap_cause;
  assign trap_epc_o = st_reg.epc;
  assign trap_tval_o = st_reg.tval;
  assign trap_taken_o = st_reg.taken;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Capture lands one cycle after the commit
  AST_CAUSE_ON_TRAP: assert property (trap_commit_i |=> trap_cause_o == $past(sel_cause) && trap_taken_o)
    else $error("cause not loaded on trap");
  AST_NO_HW_UPDATE: assert property (!trap_commit_i && !(bus_ack && avs_write_i) |=> $stable(trap_cause_o))
    else $error("cause changed without trap or write");
  AST_IRQ_FLAG: assert property (trap_commit_i |=> trap_cause_o[63] == $past(any_irq))
    else $error("interrupt flag wrong");

  // Codes and ranking for commits with a known winner, and exception PC capture
  AST_MSW_CODE: assert property (trap_commit_i && irq_msw_i && !irq_mext_i
                                 |=> trap_cause_o == 64'h8000_0000_0000_0003)
    else $error("machine software interrupt code wrong");
  AST_ILLEGAL_CODE: assert property (trap_commit_i && !any_irq && exc_illegal_i && !exc_double_i && !exc_ibreak_i &&
                                     !exc_ixlate_i && !exc_iaccess_i && !exc_hwerr_fetch_i
                                     |=> trap_cause_o == 64'h0000_0000_0000_0002)
    else $error("illegal instruction code wrong");
  AST_BREAK_FIRST: assert property (trap_commit_i && !any_irq && !exc_double_i && exc_ibreak_i
                                    |=> trap_cause_o == 64'h0000_0000_0000_0003)
    else $error("instruction breakpoint not highest");
  AST_STORE_ACCESS: assert property (trap_commit_i && !any_irq && exc_daccess_i && access_is_store_i &&
                                     !exc_dxlate_i && !(exc_dmisalign_i && st_reg.mis_first) && !exc_swcheck_i &&
                                     !exc_ebreak_i && !exc_dbreak_i && !exc_ecall_i && !exc_imisalign_i &&
                                     !exc_illegal_i && !exc_hwerr_fetch_i && !exc_iaccess_i && !exc_ixlate_i &&
                                     !exc_ibreak_i && !exc_double_i
                                     |=> trap_cause_o[5:0] == 6'h07)
    else $error("store access fault not store class");
  AST_EPC_CAPTURE: assert property (trap_commit_i |=> trap_epc_o == {$past(trap_pc_i[63:1]), 1'b0})
    else $error("exception pc not captured");

  // Exception PC, codes, trap value and pulse shape
  AST_EPC_EVEN: assert property (!trap_epc_o[0])
    else $error("exception pc bit 0 set");
  AST_TAKEN_PULSE: assert property (!trap_commit_i |=> !trap_taken_o)
    else $error("trap taken without commit");
  AST_DOUBLE_CODE: assert property (trap_commit_i && !any_irq && exc_double_i |=> trap_cause_o == 64'h10)
    else $error("double trap code wrong");
  AST_HWERR_TVAL: assert property (trap_commit_i && !any_irq && exc_code == 6'h13
                                   |=> trap_tval_o == $past(fault_vaddr_i))
    else $error("hardware error trap value wrong");

  AST_SWCHECK_TVAL: assert property (trap_commit_i && !any_irq && any_exc && exc_code == 6'h12
                                     |=> trap_tval_o == $past(swcheck_info_i))
    else $error("software check trap value wrong");
  AST_NO_RESERVED: assert property (trap_commit_i && !any_irq
                                    |=> !(trap_cause_o[5:0] >= 6'h20 && trap_cause_o[5:0] <= 6'h2F))
    else $error("reserved code produced");

  // One wait cycle per taken access
  AST_BUS_ANSWER: assert property (bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");

  // Main scenarios
  COV_IRQ_TRAP: cover property (trap_commit_i && any_irq);
  COV_MULTI_EXC: cover property (trap_commit_i && exc_illegal_i && exc_dmisalign_i);
  COV_SW_WRITE: cover property (bus_ack && avs_write_i && avs_address_i == trap_cause_pkg::REG_CAUSE_HI);
  COV_TRAP_AND_WRITE: cover property (trap_commit_i && bus_ack && avs_write_i);
  COV_MIS_FIRST: cover property (trap_commit_i && exc_dmisalign_i && st_reg.mis_first);

endmodule

// ==== tb/hart_model.sv ====
// Purpose: Pipeline stand-in that raises trap commits, interrupts and exceptions.
// Assumes: Bench sets a request just after a rising edge and holds go_i for one cycle per trap.
// Notes: Outside a commit the lines show the inverse of the last request, so stale values never look valid.
module hart_model (
  // Clock
  input wire logic sys_clk_i,
  // Requests from the bench
  input wire logic go_i,
  input wire logic [6:0] irq_i,
  input wire logic [17:0] exc_i,
  input wire logic [5:0] code_i,
  // Pipeline side
  output logic commit_o,
  output logic [6:0] irq_o,
  output logic [17:0] exc_o,
  output logic [5:0] code_o
);
  logic [6:0] irq_last = 7'h00;
  logic [17:0] exc_last = 18'h00000;
  logic [5:0] code_last = 6'h00;

  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      irq_last <= irq_i;
      exc_last <= exc_i;
      code_last <= code_i;
    end
  end

  always_comb begin
    commit_o = go_i;
    irq_o = go_i ? irq_i : ~irq_last;
    exc_o = go_i ? exc_i : ~exc_last;
    code_o = go_i ? code_i : ~code_last;
  end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the machine trap cause logic.
// Assumes: Traps enter through hart_model; registers are reached over Avalon-MM.
// Notes: Ordinary traps come from a row table; register, rank, back-to-back cases follow.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [6:0] irq;
    logic [17:0] exc;
    logic [1:0] priv;
    logic st;
    logic [5:0] cc;
    logic fl;
    logic [5:0] code;
    logic [1:0] tv;
  } row_t;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic go = 1'b0;
  logic st = 1'b0;
  logic [1:0] priv = 2'h0;
  logic [6:0] irq = 7'h00;
  logic [17:0] exc = 18'h00000;
  logic [5:0] cc = 6'h00;
  logic [63:0] pc = 64'h0000_0000_8000_0101;
  logic [63:0] va = 64'h1234_5678_0000_00A4;
  logic [63:0] info = 64'h0000_0000_0000_0003;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, trap_taken_o, commit_w;
  logic [63:0] trap_cause_o, trap_epc_o, trap_tval_o;
  logic [6:0] irq_w;
  logic [17:0] e;
  logic [5:0] cc_w;
  int failures = 0;
  int cmp_count = 0;
  // tv: 0 zero, 1 faulting address, 2 check info, 3 not compared
  row_t rows [33] = '{
    '{7'h01, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h01, 2'h0}, '{7'h02, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h03, 2'h0},
    '{7'h04, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h05, 2'h0}, '{7'h08, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h07, 2'h0},
    '{7'h10, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h09, 2'h0}, '{7'h20, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h0B, 2'h0},
    '{7'h40, 18'h00000, 2'h0, 1'b0, 6'h00, 1'b1, 6'h0D, 2'h0}, '{7'h22, 18'h3FFFF, 2'h0, 1'b0, 6'h18, 1'b1, 6'h0B, 2'h0},
    '{7'h00, 18'h00046, 2'h0, 1'b0, 6'h00, 1'b0, 6'h03, 2'h1}, '{7'h00, 18'h0001C, 2'h0, 1'b0, 6'h00, 1'b0, 6'h0C, 2'h1},
    '{7'h00, 18'h00014, 2'h0, 1'b0, 6'h00, 1'b0, 6'h01, 2'h1}, '{7'h00, 18'h00050, 2'h0, 1'b0, 6'h00, 1'b0, 6'h01, 2'h1},
    '{7'h00, 18'h000C0, 2'h0, 1'b0, 6'h00, 1'b0, 6'h02, 2'h0}, '{7'h00, 18'h00180, 2'h0, 1'b0, 6'h00, 1'b0, 6'h00, 2'h1},
    '{7'h00, 18'h00100, 2'h0, 1'b0, 6'h00, 1'b0, 6'h08, 2'h0}, '{7'h00, 18'h00100, 2'h1, 1'b0, 6'h00, 1'b0, 6'h09, 2'h0},
    '{7'h00, 18'h00100, 2'h3, 1'b0, 6'h00, 1'b0, 6'h0B, 2'h0}, '{7'h00, 18'h01200, 2'h0, 1'b0, 6'h00, 1'b0, 6'h03, 2'h1},
    '{7'h00, 18'h00400, 2'h0, 1'b0, 6'h00, 1'b0, 6'h03, 2'h1}, '{7'h00, 18'h02800, 2'h0, 1'b0, 6'h00, 1'b0, 6'h12, 2'h2},
    '{7'h00, 18'h06000, 2'h0, 1'b0, 6'h00, 1'b0, 6'h0D, 2'h1}, '{7'h00, 18'h06000, 2'h0, 1'b1, 6'h00, 1'b0, 6'h0F, 2'h1},
    '{7'h00, 18'h0A000, 2'h0, 1'b0, 6'h00, 1'b0, 6'h05, 2'h1}, '{7'h00, 18'h0A000, 2'h0, 1'b1, 6'h00, 1'b0, 6'h07, 2'h1},
    '{7'h00, 18'h09000, 2'h0, 1'b0, 6'h00, 1'b0, 6'h05, 2'h1}, '{7'h00, 18'h01000, 2'h0, 1'b0, 6'h00, 1'b0, 6'h04, 2'h1},
    '{7'h00, 18'h01000, 2'h0, 1'b1, 6'h00, 1'b0, 6'h06, 2'h1}, '{7'h00, 18'h11000, 2'h0, 1'b0, 6'h00, 1'b0, 6'h13, 2'h1},
    '{7'h00, 18'h00021, 2'h0, 1'b0, 6'h00, 1'b0, 6'h10, 2'h0}, '{7'h00, 18'h00060, 2'h0, 1'b0, 6'h00, 1'b0, 6'h13, 2'h1},
    '{7'h00, 18'h21000, 2'h0, 1'b0, 6'h18, 1'b0, 6'h04, 2'h1}, '{7'h00, 18'h20000, 2'h0, 1'b0, 6'h3F, 1'b0, 6'h3F, 2'h0},
    '{7'h00, 18'h20000, 2'h0, 1'b0, 6'h20, 1'b0, 6'h00, 2'h3}};

  always #12.5 sys_clk_i = ~sys_clk_i;

  hart_model u_hart_model (.sys_clk_i(sys_clk_i), .go_i(go), .irq_i(irq), .exc_i(exc), .code_i(cc),
    .commit_o(commit_w), .irq_o(irq_w), .exc_o(e), .code_o(cc_w));

  machine_trap_cause_logic u_machine_trap_cause_logic (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .trap_commit_i(commit_w), .trap_pc_i(pc), .fault_vaddr_i(va), .swcheck_info_i(info), .priv_i(priv),
    .access_is_store_i(st), .irq_ssw_i(irq_w[0]), .irq_msw_i(irq_w[1]), .irq_stimer_i(irq_w[2]),
    .irq_mtimer_i(irq_w[3]), .irq_sext_i(irq_w[4]), .irq_mext_i(irq_w[5]), .irq_lcof_i(irq_w[6]),
    .exc_double_i(e[0]), .exc_ibreak_i(e[1]), .exc_ixlate_i(e[2]), .exc_ixlate_page_i(e[3]), .exc_iaccess_i(e[4]),
    .exc_hwerr_fetch_i(e[5]), .exc_illegal_i(e[6]), .exc_imisalign_i(e[7]), .exc_ecall_i(e[8]), .exc_ebreak_i(e[9]),
    .exc_dbreak_i(e[10]), .exc_swcheck_i(e[11]), .exc_dmisalign_i(e[12]), .exc_dxlate_i(e[13]),
    .exc_dxlate_page_i(e[14]), .exc_daccess_i(e[15]), .exc_hwerr_data_i(e[16]), .exc_custom_i(e[17]),
    .exc_custom_code_i(cc_w), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trap_cause_o(trap_cause_o), .trap_epc_o(trap_epc_o),
    .trap_tval_o(trap_tval_o), .trap_taken_o(trap_taken_o));

  // ==========================================================================
  // Tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    r = avs_readdata_o;
    if (avs_waitrequest_o !== 1'b0) begin
      failures++;
      print_verdict();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic drive(input row_t r);
    irq <= r.irq;
    exc <= r.exc;
    priv <= r.priv;
    st <= r.st;
    cc <= r.cc;
    go <= 1'b1;
  endtask

  task automatic check(input row_t r);
    logic [63:0] tv;
    tv = (r.tv == 2'h1) ? va : ((r.tv == 2'h2) ? info : 64'h0);
    chk(trap_cause_o, {r.fl, 57'h0, r.code});
    chk(trap_epc_o, pc & ~64'h1);
    if (r.tv != 2'h3) chk(trap_tval_o, tv);
  endtask

  task automatic trap(input row_t r);
    int n;
    drive(r);
    @(posedge sys_clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (trap_taken_o !== 1'b1 && n < 20);
    if (trap_taken_o !== 1'b1) begin
      failures++;
      print_verdict();
    end
    check(r);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    chk({63'h0, avs_waitrequest_o}, 64'h1);
    chk(trap_cause_o, trap_cause_pkg::CAUSE_RESET);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 33; i++) begin
      trap(rows[i]);
      chk(trap_cause_o, {rows[i].fl, 57'h0, rows[i].code});
    end
    // Software writes both halves; nothing but a trap may move them afterwards
    bus(1'b1, trap_cause_pkg::REG_CAUSE_LO, 32'h0000_0012, q);
    bus(1'b1, trap_cause_pkg::REG_CAUSE_HI, 32'h8000_0000, q);
    repeat (5) @(posedge sys_clk_i);
    chk(trap_cause_o, 64'h8000_0000_0000_0012);
    bus(1'b0, trap_cause_pkg::REG_CAUSE_LO, 32'h0, q);
    chk({32'h0, q}, 64'h12);
    bus(1'b0, trap_cause_pkg::REG_CAUSE_HI, 32'h0, q);
    chk({32'h0, q}, 64'h8000_0000);
    bus(1'b0, 4'h8, 32'h0, q);
    chk({32'h0, q}, {32'h0, trap_cause_pkg::UNMAPPED_READ});
    // Misaligned rank switch: first above the data faults, then back below them
    for (int m = 1; m >= 0; m--) begin
      bus(1'b1, trap_cause_pkg::REG_CTRL, {31'h0, m[0]}, q);
      trap('{7'h00, 18'h07000, 2'h0, 1'b0, 6'h00, 1'b0, (m == 1) ? 6'h04 : 6'h0D, 2'h1});
    end
    // Back-to-back commits, each captured in its own cycle
    drive(rows[0]);
    @(posedge sys_clk_i);
    drive(rows[14]);
    @(posedge sys_clk_i);
    go <= 1'b0;
    check(rows[0]);
    @(posedge sys_clk_i);
    check(rows[14]);
    bus(1'b0, trap_cause_pkg::REG_STATUS, 32'h0, q);
    chk({32'h0, q}, 64'h2);
    // Reset in mid-run clears capture; after release the bus still takes one wait cycle and answers at the second edge
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(trap_cause_o, trap_cause_pkg::CAUSE_RESET);
    chk(trap_epc_o, trap_cause_pkg::EPC_RESET);
    nrst_i <= 1'b1;
    bus(1'b0, trap_cause_pkg::REG_STATUS, 32'h0, q);
    chk({32'h0, q}, 64'h0);
    print_verdict();
  end
endmodule
